// *** design/ssec_regs.vh ***
`ifndef SSEC_REGS_VH
`define SSEC_REGS_VH

// Opcodes
`define SSEC_OP_LOOP_ON 8'h84
`define SSEC_OP_LOOP_OFF 8'h85
`define SSEC_OP_DIVISOR 8'h86
`define SSEC_OP_FLUSH 8'h87
`define SSEC_OP_WAIT_HI 8'h88
`define SSEC_OP_WAIT_LO 8'h89
`define SSEC_OP_PRE_OFF 8'h8a
`define SSEC_OP_PRE_ON 8'h8b
`define SSEC_OP_TRI_ON 8'h8c
`define SSEC_OP_TRI_OFF 8'h8d
`define SSEC_OP_CLK_BITS 8'h8e
`define SSEC_OP_CLK_BYTES 8'h8f
`define SSEC_OP_RD_SHORT 8'h90
`define SSEC_OP_RD_EXT 8'h91
`define SSEC_OP_WR_SHORT 8'h92
`define SSEC_OP_WR_EXT 8'h93
`define SSEC_OP_CLK_UNTIL_HI 8'h94
`define SSEC_OP_CLK_UNTIL_LO 8'h95
`define SSEC_OP_ADAPT_ON 8'h96
`define SSEC_OP_ADAPT_OFF 8'h97
`define SSEC_OP_CLKN_UNTIL_HI 8'h9c
`define SSEC_OP_CLKN_UNTIL_LO 8'h9d

// Prescaler: divide by 5, counter runs 0..4
`define SSEC_PRESCALE_LAST 3'h4

// Reset values of persistent settings
`define SSEC_DIVISOR_RST 16'h0000
`define SSEC_PRESCALE_RST 1'b1
`define SSEC_TRI_RST 1'b0
`define SSEC_LOOP_RST 1'b0
`define SSEC_ADAPT_RST 1'b0

// Bus cycle phases, one system clock each
`define SSEC_BUS_ALE_OFF 3'h1
`define SSEC_BUS_STROBE 3'h2
`define SSEC_BUS_END 3'h5

`endif

// *** design/ssec_sync.v ***
`timescale 1ns/1ps
module ssec_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rstn,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta;

	always @(posedge clk) begin
		if (!rstn) begin
			meta <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // ssec_sync

// *** design/ssec_tick.v ***
`timescale 1ns/1ps
`include "ssec_regs.vh"
module ssec_tick (
	input wire clk,
	input wire rstn,
	input wire run,
	input wire prescale_on,
	input wire [15:0] divisor,
	output reg half_tick
);
	reg [2:0] pre_cnt;
	reg [15:0] div_cnt;
	wire pre_en;

	// Divide by 5 ahead of the divisor, or bypassed
	assign pre_en = !prescale_on || (pre_cnt == `SSEC_PRESCALE_LAST);

	always @(posedge clk) begin
		if (!rstn || !run) begin
			// Restart so every command begins with a full half period
			pre_cnt <= 3'h0;
			div_cnt <= 16'h0000;
			half_tick <= 1'b0;
		end else begin
			half_tick <= 1'b0;
			if (pre_en)
				pre_cnt <= 3'h0;
			else
				pre_cnt <= pre_cnt + 3'h1;
			if (pre_en) begin
				// Half period is N+1 master ticks
				if (div_cnt == divisor) begin
					div_cnt <= 16'h0000;
					half_tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 16'h0001;
				end
			end
		end
	end
endmodule // ssec_tick

// *** design/ssec_top.v ***
// Summary of operation
// - Loopback opcodes connect or disconnect data out-in
// - Divisor low/high bytes; 12MHz over (1+N)*2
// - Prescaler off: 60MHz over (1+N)*2 for N>=1; over 4 for N=0
// - 50% duty with three-phase off; idle at configured level between commands
// - Idle-low clock pulses high then low
// - Divide-by-5 stage ahead of divisor
// - Prescaler-off opcode bypasses divide-by-5
// - Prescaler-on opcode restores divide-by-5
// - Multiplexed address/data bus with strobes and oscillator
// - Short or extended read returns one byte
// - Short or extended write does one write
// - Send-immediate flushes pending response bytes
// - Wait-high stalls until wait line high
// - Wait-low stalls until wait line low
// - No timeout; disabling controller abandons wait
// - Three-phase opcodes hold data both edges
// - Setup, pulse, hold halves; two-phase default
// - Bit-count clock-only pulses, no data
// - Bit length L gives L+1 pulses
// - Byte-count clock-only pulses, groups of eight
// - Byte length L gives 8*(L+1) pulses
// - Continuous clocking until wait line level
// - Counted clocking until level or count
// - Adaptive clocking waits for returned clock match
`timescale 1ns/1ps
`include "ssec_regs.vh"
module ssec_top (
	input wire CLK_SYS,
	input wire RSTN,
	input wire CTRL_ENABLE,
	input wire CPU_MODE,
	input wire CLK_IDLE_LEVEL,
	input wire [7:0] CMD_DATA,
	input wire CMD_VALID,
	output reg CMD_READY,
	output reg [7:0] RESP_DATA,
	output reg RESP_VALID,
	input wire RESP_READY,
	output reg RESP_FLUSH,
	output reg SHIFT_CLOCK_OUT,
	input wire SER_DATA_SRC,
	output reg SER_DATA_OUT,
	input wire SERIAL_DATA_IN,
	output reg SER_DATA_SEEN,
	input wire WAIT_INPUT_LINE,
	input wire RETURN_CLOCK_INPUT,
	input wire [1:0] CPU_IO_IN,
	output reg [1:0] CPU_IO_STATE,
	input wire [7:0] BUS_AD_IN,
	output reg [7:0] BUS_AD_OUT,
	output reg BUS_AD_OE,
	output reg [7:0] BUS_ADDR_HI,
	output reg BUS_CS_N,
	output reg BUS_ALE,
	output reg BUS_WR_N,
	output reg BUS_RD_N,
	output reg BUS_OSCILLATOR_OUT,
	output reg [15:0] DIVISOR,
	output reg PRESCALE_ON,
	output reg THREE_PHASE_ON,
	output reg LOOPBACK_ON,
	output reg ADAPTIVE_ON,
	output reg BUSY
);
	localparam S_OP = 3'h0;
	localparam S_ARG = 3'h1;
	localparam S_EXEC = 3'h2;
	localparam S_CLK = 3'h3;
	localparam S_WAIT = 3'h4;
	localparam S_BUS = 3'h5;
	localparam S_RESP = 3'h6;

	reg [2:0] state;
	reg [7:0] op;
	reg [7:0] args [0:2];
	reg [1:0] argi;
	reg [1:0] need;
	reg [1:0] ph;
	reg [18:0] remain;
	reg unbounded;
	reg stop_on_level;
	reg stop_level;
	reg idle;
	reg half_pend;
	reg [2:0] bus_ph;
	reg bus_read;
	reg [7:0] bus_data;
	wire [12:0] sync_q;
	wire half_tick;
	wire ser_in_s;
	wire returned_clock_s;
	wire wait_s;
	wire take;
	wire step;
	wire pulse_end;

	// Argument bytes following each opcode
	function [1:0] arg_count;
		input [7:0] code;
		begin
			case (code)
			`SSEC_OP_DIVISOR: arg_count = 2'h2;
			`SSEC_OP_CLK_BITS: arg_count = 2'h1;
			`SSEC_OP_CLK_BYTES: arg_count = 2'h2;
			`SSEC_OP_CLKN_UNTIL_HI: arg_count = 2'h2;
			`SSEC_OP_CLKN_UNTIL_LO: arg_count = 2'h2;
			`SSEC_OP_RD_SHORT: arg_count = 2'h1;
			`SSEC_OP_RD_EXT: arg_count = 2'h2;
			`SSEC_OP_WR_SHORT: arg_count = 2'h2;
			`SSEC_OP_WR_EXT: arg_count = 2'h3;
			default: arg_count = 2'h0;
			endcase
		end
	endfunction

	ssec_sync #(
		.W(13)
	) u_sync (
		.clk(CLK_SYS),
		.rstn(RSTN),
		.d({SERIAL_DATA_IN, WAIT_INPUT_LINE, RETURN_CLOCK_INPUT, CPU_IO_IN, BUS_AD_IN}),
		.q(sync_q)
	);

	assign ser_in_s = sync_q[12];
	assign returned_clock_s = sync_q[10];
	// In CPU mode the first I/O line is the wait source
	assign wait_s = CPU_MODE ? sync_q[8] : sync_q[11];

	ssec_tick u_tick (
		.clk(CLK_SYS),
		.rstn(RSTN),
		.run(state == S_CLK),
		.prescale_on(PRESCALE_ON),
		.divisor(DIVISOR),
		.half_tick(half_tick)
	);

	assign take = CMD_VALID && CMD_READY;
	// With adaptive clocking on, a clock edge may only move once the target has echoed the last one
	assign step = half_pend && (!ADAPTIVE_ON || returned_clock_s == SHIFT_CLOCK_OUT);
	// Two halves per pulse, or three with the hold half
	assign pulse_end = step && ((ph == 2'h1 && !THREE_PHASE_ON) || ph == 2'h2);

	// Free-running bus oscillator at half the system clock
	always @(posedge CLK_SYS) begin
		if (!RSTN)
			BUS_OSCILLATOR_OUT <= 1'b0;
		else
			BUS_OSCILLATOR_OUT <= !BUS_OSCILLATOR_OUT;
	end

	// Loopback is applied after the pin sync, so the looped path skips its two sync stages
	always @(posedge CLK_SYS) begin
		if (!RSTN) begin
			SER_DATA_OUT <= 1'b0;
			SER_DATA_SEEN <= 1'b0;
			CPU_IO_STATE <= 2'h0;
		end else begin
			SER_DATA_OUT <= SER_DATA_SRC;
			SER_DATA_SEEN <= LOOPBACK_ON ? SER_DATA_OUT : ser_in_s;
			CPU_IO_STATE <= sync_q[9:8];
		end
	end

	always @(posedge CLK_SYS) begin
		if (!RSTN || !CTRL_ENABLE) begin
			// Disabling is the only way out of a stalled wait
			state <= S_OP;
			CMD_READY <= 1'b0;
			RESP_VALID <= 1'b0;
			RESP_DATA <= 8'h00;
			RESP_FLUSH <= 1'b0;
			SHIFT_CLOCK_OUT <= CLK_IDLE_LEVEL && RSTN;
			BUS_AD_OUT <= 8'h00;
			BUS_AD_OE <= 1'b0;
			BUS_ADDR_HI <= 8'h00;
			BUS_CS_N <= 1'b1;
			BUS_ALE <= 1'b0;
			BUS_WR_N <= 1'b1;
			BUS_RD_N <= 1'b1;
			BUSY <= 1'b0;
			op <= 8'h00;
			argi <= 2'h0;
			need <= 2'h0;
			ph <= 2'h0;
			remain <= 19'h00000;
			unbounded <= 1'b0;
			stop_on_level <= 1'b0;
			stop_level <= 1'b0;
			idle <= 1'b0;
			half_pend <= 1'b0;
			bus_ph <= 3'h0;
			bus_read <= 1'b0;
			bus_data <= 8'h00;
			if (!RSTN) begin
				DIVISOR <= `SSEC_DIVISOR_RST;
				PRESCALE_ON <= `SSEC_PRESCALE_RST;
				THREE_PHASE_ON <= `SSEC_TRI_RST;
				LOOPBACK_ON <= `SSEC_LOOP_RST;
				ADAPTIVE_ON <= `SSEC_ADAPT_RST;
			end
		end else begin
			RESP_FLUSH <= 1'b0;
			case (state)
			S_OP: begin
				BUSY <= 1'b0;
				CMD_READY <= 1'b1;
				// Between commands the clock rests at the configured level
				SHIFT_CLOCK_OUT <= CLK_IDLE_LEVEL;
				idle <= CLK_IDLE_LEVEL;
				if (take) begin
					op <= CMD_DATA;
					need <= arg_count(CMD_DATA);
					argi <= 2'h0;
					BUSY <= 1'b1;
					if (arg_count(CMD_DATA) == 2'h0) begin
						CMD_READY <= 1'b0;
						state <= S_EXEC;
					end else begin
						state <= S_ARG;
					end
				end
			end
			S_ARG: begin
				if (take) begin
					args[argi] <= CMD_DATA;
					argi <= argi + 2'h1;
					if (argi + 2'h1 == need) begin
						CMD_READY <= 1'b0;
						state <= S_EXEC;
					end
				end
			end
			S_EXEC: begin
				// One command at a time keeps execution and replies in order
				state <= S_OP;
				ph <= 2'h0;
				half_pend <= 1'b0;
				unbounded <= 1'b0;
				stop_on_level <= 1'b0;
				stop_level <= op[0] ? 1'b0 : 1'b1;
				case (op)
				`SSEC_OP_LOOP_ON: LOOPBACK_ON <= 1'b1;
				`SSEC_OP_LOOP_OFF: LOOPBACK_ON <= 1'b0;
				`SSEC_OP_DIVISOR: DIVISOR <= {args[1], args[0]};
				`SSEC_OP_PRE_OFF: PRESCALE_ON <= 1'b0;
				`SSEC_OP_PRE_ON: PRESCALE_ON <= 1'b1;
				`SSEC_OP_TRI_ON: THREE_PHASE_ON <= 1'b1;
				`SSEC_OP_TRI_OFF: THREE_PHASE_ON <= 1'b0;
				`SSEC_OP_ADAPT_ON: ADAPTIVE_ON <= 1'b1;
				`SSEC_OP_ADAPT_OFF: ADAPTIVE_ON <= 1'b0;
				`SSEC_OP_FLUSH: RESP_FLUSH <= 1'b1;
				`SSEC_OP_WAIT_HI, `SSEC_OP_WAIT_LO: state <= S_WAIT;
				`SSEC_OP_CLK_BITS: begin
					remain <= {16'h0000, args[0][2:0]};
					state <= S_CLK;
				end
				`SSEC_OP_CLK_BYTES: begin
					remain <= {args[1], args[0], 3'h7};
					state <= S_CLK;
				end
				`SSEC_OP_CLK_UNTIL_HI, `SSEC_OP_CLK_UNTIL_LO: begin
					unbounded <= 1'b1;
					stop_on_level <= 1'b1;
					state <= S_CLK;
				end
				`SSEC_OP_CLKN_UNTIL_HI, `SSEC_OP_CLKN_UNTIL_LO: begin
					remain <= {args[1], args[0], 3'h7};
					stop_on_level <= 1'b1;
					state <= S_CLK;
				end
				`SSEC_OP_RD_SHORT, `SSEC_OP_RD_EXT, `SSEC_OP_WR_SHORT, `SSEC_OP_WR_EXT: begin
					bus_read <= !op[1];
					BUS_ADDR_HI <= op[0] ? args[0] : 8'h00;
					BUS_AD_OUT <= op[0] ? args[1] : args[0];
					bus_data <= op[0] ? args[2] : args[1];
					// Address goes out with the latch strobe first
					BUS_AD_OE <= 1'b1;
					BUS_ALE <= 1'b1;
					bus_ph <= 3'h0;
					state <= S_BUS;
				end
				default: state <= S_OP;
				endcase
			end
			S_WAIT: begin
				// No timeout here
				if (wait_s == !op[0])
					state <= S_OP;
			end
			S_CLK: begin
				if (half_tick)
					half_pend <= 1'b1;
				if (step) begin
					half_pend <= 1'b0;
					case (ph)
					2'h0: begin
						if (stop_on_level && wait_s == stop_level) begin
							state <= S_OP;
						end else begin
							SHIFT_CLOCK_OUT <= !idle;
							ph <= 2'h1;
						end
					end
					2'h1: begin
						SHIFT_CLOCK_OUT <= idle;
						ph <= THREE_PHASE_ON ? 2'h2 : 2'h0;
					end
					default: ph <= 2'h0;
					endcase
				end
				if (pulse_end && !unbounded) begin
					if (remain == 19'h00000)
						state <= S_OP;
					else
						remain <= remain - 19'h00001;
				end
			end
			S_BUS: begin
				bus_ph <= bus_ph + 3'h1;
				case (bus_ph)
				`SSEC_BUS_ALE_OFF: BUS_ALE <= 1'b0;
				`SSEC_BUS_STROBE: begin
					BUS_CS_N <= 1'b0;
					BUS_RD_N <= !bus_read;
					BUS_WR_N <= bus_read;
					BUS_AD_OE <= !bus_read;
					BUS_AD_OUT <= bus_data;
				end
				`SSEC_BUS_END: begin
					BUS_CS_N <= 1'b1;
					BUS_RD_N <= 1'b1;
					BUS_WR_N <= 1'b1;
					BUS_AD_OE <= 1'b0;
					if (bus_read) begin
						// Synced bus value lags two cycles, so strobe is held long enough
						RESP_DATA <= sync_q[7:0];
						RESP_VALID <= 1'b1;
						state <= S_RESP;
					end else begin
						state <= S_OP;
					end
				end
				default: bus_ph <= bus_ph + 3'h1;
				endcase
			end
			S_RESP: begin
				if (RESP_READY) begin
					RESP_VALID <= 1'b0;
					state <= S_OP;
				end
			end
			default: state <= S_OP;
			endcase
		end
	end
endmodule // ssec_top

// *** bench/ssec_target.sv ***
`timescale 1ns/1ps
module ssec_target (
	input wire clk,
	input wire slow,
	input wire sck,
	input wire [7:0] ad_out,
	input wire [7:0] ad_hi,
	input wire ale,
	input wire cs_n,
	input wire rd_n,
	input wire wr_n,
	output wire [7:0] ad_in,
	output reg returned_clock,
	output reg [15:0] wr_seen
);
	reg [15:0] addr;
	reg [7:0] junk = 8'h5a;
	reg [5:0] dly = 6'h0;
	// Released bus moves every cycle so a stale byte never passes
	assign ad_in = (!cs_n && !rd_n) ? addr[15:8] ^ addr[7:0] ^ 8'ha5 : junk;
	always @(posedge clk) begin
		junk <= ~junk;
		dly <= {dly[4:0], sck};
		returned_clock <= slow ? dly[5] : dly[0];
		if (ale)
			addr <= {ad_hi, ad_out};
		if (!cs_n && !wr_n)
			wr_seen <= {addr[7:0], ad_out};
	end
endmodule // ssec_target

// *** bench/ssec_assertions.sv ***
`timescale 1ns/1ps
module ssec_assertions (
	input wire CLK_SYS,
	input wire RSTN,
	input wire CTRL_ENABLE,
	input wire CLK_IDLE_LEVEL,
	input wire [7:0] CMD_DATA,
	input wire CMD_VALID,
	input wire CMD_READY,
	input wire RESP_FLUSH,
	input wire SHIFT_CLOCK_OUT,
	input wire BUS_ALE,
	input wire BUS_CS_N,
	input wire [15:0] DIVISOR,
	input wire PRESCALE_ON,
	input wire THREE_PHASE_ON,
	input wire LOOPBACK_ON,
	input wire ADAPTIVE_ON
);
	reg op_next;
	reg [19:0] hcnt;
	wire op = CMD_VALID && CMD_READY && op_next;
	wire [19:0] half = ({4'h0, DIVISOR} + 20'h1) * (PRESCALE_ON ? 20'h5 : 20'h1);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN || !CTRL_ENABLE);
	// Argument bytes may equal opcodes, so only the first byte counts
	always @(posedge CLK_SYS) begin
		op_next <= !RSTN || !CTRL_ENABLE || !CMD_READY || (op_next && !CMD_VALID);
		hcnt <= $changed(SHIFT_CLOCK_OUT) ? 20'h1 : hcnt + 20'h1;
	end
	loop_on_a: assert property (op && CMD_DATA == 8'h84 |-> ##[1:3] LOOPBACK_ON) else $error("loopback off");
	pre_off_a: assert property (op && CMD_DATA == 8'h8a |-> ##[1:3] !PRESCALE_ON) else $error("prescaler on");
	flush_a: assert property (op && CMD_DATA == 8'h87 |-> ##[1:3] RESP_FLUSH) else $error("no flush");
	settings_a: assert property ($past(CMD_READY) && CMD_READY && !CMD_VALID |=>
		$stable({DIVISOR, PRESCALE_ON, THREE_PHASE_ON, LOOPBACK_ON, ADAPTIVE_ON})) else $error("setting moved");
	cs_order_a: assert property ($fell(BUS_CS_N) |-> $past(BUS_ALE, 3) && !BUS_ALE) else $error("no latch");
	cs_len_a: assert property ($fell(BUS_CS_N) |-> !BUS_CS_N [*3] ##1 BUS_CS_N) else $error("select length");
	half_a: assert property ($fell(SHIFT_CLOCK_OUT) && !ADAPTIVE_ON && !CLK_IDLE_LEVEL |->
		hcnt == half) else $error("half period");
	idle_a: assert property (CMD_READY |-> SHIFT_CLOCK_OUT == CLK_IDLE_LEVEL) else $error("clock not idle");
endmodule // ssec_assertions
bind ssec_top ssec_assertions i_ssec_assertions (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CTRL_ENABLE(CTRL_ENABLE),
	.CLK_IDLE_LEVEL(CLK_IDLE_LEVEL), .CMD_DATA(CMD_DATA), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
	.RESP_FLUSH(RESP_FLUSH), .SHIFT_CLOCK_OUT(SHIFT_CLOCK_OUT), .BUS_ALE(BUS_ALE), .BUS_CS_N(BUS_CS_N),
	.DIVISOR(DIVISOR), .PRESCALE_ON(PRESCALE_ON), .THREE_PHASE_ON(THREE_PHASE_ON),
	.LOOPBACK_ON(LOOPBACK_ON), .ADAPTIVE_ON(ADAPTIVE_ON));

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
	reg clk = 0, rstn = 0, en = 1, cpu = 0, vld = 0, src = 0, wline = 0, slow = 0;
	reg [7:0] cdat = 8'h00;
	reg [1:0] cio = 2'h0;
	wire rdy, rv, fl, sck, seen, returned_clock, ale, cs_n, wr_n, rd_n, pre, tph, loop, adapt, osc, busy, oe, sdo;
	wire [1:0] cst;
	wire [7:0] rd, ad_out, ad_in, ad_hi;
	wire [15:0] div, wr_seen;
	integer miscompares = 0, checks_done = 0, pulses = 0, hi = 0, flushes = 0, oes = 0, p0, h0;
	reg [7:0] rq[$];
	always #10 clk = ~clk;
	always @(posedge sck) pulses = pulses + 1;
	always @(posedge clk) begin
		hi <= hi + sck;
		flushes <= flushes + fl;
		oes <= oes + oe;
		if (rv)
			rq.push_back(rd);
	end
	ssec_top i_ssec_top (.CLK_SYS(clk), .RSTN(rstn), .CTRL_ENABLE(en), .CPU_MODE(cpu), .CLK_IDLE_LEVEL(1'b0),
		.CMD_DATA(cdat), .CMD_VALID(vld), .CMD_READY(rdy), .RESP_DATA(rd), .RESP_VALID(rv), .RESP_READY(1'b1),
		.RESP_FLUSH(fl), .SHIFT_CLOCK_OUT(sck), .SER_DATA_SRC(src), .SER_DATA_OUT(sdo), .SERIAL_DATA_IN(1'b0),
		.SER_DATA_SEEN(seen), .WAIT_INPUT_LINE(wline), .RETURN_CLOCK_INPUT(returned_clock), .CPU_IO_IN(cio),
		.CPU_IO_STATE(cst), .BUS_AD_IN(ad_in), .BUS_AD_OUT(ad_out), .BUS_AD_OE(oe), .BUS_ADDR_HI(ad_hi),
		.BUS_CS_N(cs_n), .BUS_ALE(ale), .BUS_WR_N(wr_n), .BUS_RD_N(rd_n), .BUS_OSCILLATOR_OUT(osc),
		.DIVISOR(div), .PRESCALE_ON(pre), .THREE_PHASE_ON(tph), .LOOPBACK_ON(loop), .ADAPTIVE_ON(adapt),
		.BUSY(busy));
	ssec_target i_ssec_target (.clk(clk), .slow(slow), .sck(sck), .ad_out(ad_out), .ad_hi(ad_hi), .ale(ale),
		.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in), .returned_clock(returned_clock), .wr_seen(wr_seen));
	task check(input string nm, input [19:0] got, input [19:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task wait_rdy;
		integer t;
		begin
			t = 0;
			@(posedge clk);
			while (rdy !== 1'b1 && t < 9999) begin
				t = t + 1;
				@(posedge clk);
			end
			if (t == 9999)
				check("ready", rdy, 1);
		end
	endtask
	// Valid stays up between bytes, dropped only after the last one
	task go(input [31:0] b, input integer n);
		integer i;
		begin
			for (i = n - 1; i >= 0; i = i - 1) begin
				cdat <= b[8*i +: 8];
				vld <= 1'b1;
				wait_rdy;
			end
			vld <= 1'b0;
		end
	endtask
	task cmd(input [31:0] b, input integer n);
		begin
			go(b, n);
			wait_rdy;
		end
	endtask
	task run(input [31:0] b, input integer n, input integer ep, input integer eh);
		begin
			p0 = pulses;
			h0 = hi;
			cmd(b, n);
			check("pulses", pulses - p0, ep);
			if (eh > 0)
				check("high time", hi - h0, eh);
		end
	endtask
	initial begin
		#1500000;
		miscompares = miscompares + 1;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		check("divisor", div, 0);
		check("prescale", pre, 1);
		check("three phase", tph, 0);
		check("loopback", loop, 0);
		check("adaptive", adapt, 0);
		cmd(8'h84, 1);
		src <= 1'b1;
		repeat (4) @(posedge clk);
		check("seen", seen, 1);
		check("data out", sdo, 1);
		h0 = osc;
		@(posedge clk);
		check("oscillator", osc, !h0);
		cmd(8'h85, 1);
		repeat (4) @(posedge clk);
		check("seen", seen, 0);
		// Divisor 2: half period 15 cycles with prescaler, 3 without
		cmd(24'h860200, 3);
		run(16'h8e07, 2, 8, 120);
		run(16'h8e00, 2, 1, 15);
		cmd(8'h8a, 1);
		check("prescale", pre, 0);
		run(24'h8f0100, 3, 16, 48);
		cmd(8'h8c, 1);
		check("three phase", tph, 1);
		run(16'h8e03, 2, 4, 12);
		cmd(8'h8d, 1);
		check("three phase", tph, 0);
		wline <= 1'b1;
		repeat (3) @(posedge clk);
		run(24'h9c0000, 3, 0, 0);
		run(24'h9d0000, 3, 8, 24);
		run(8'h94, 1, 0, 0);
		wline <= 1'b0;
		repeat (3) @(posedge clk);
		run(8'h95, 1, 0, 0);
		p0 = pulses;
		go(8'h94, 1);
		repeat (60) @(posedge clk);
		wline <= 1'b1;
		wait_rdy;
		check("pulses", pulses - p0 > 5, 1);
		go(8'h89, 1);
		repeat (30) @(posedge clk);
		check("ready", rdy, 0);
		wline <= 1'b0;
		wait_rdy;
		cpu <= 1'b1;
		go(8'h88, 1);
		repeat (30) @(posedge clk);
		check("ready", rdy, 0);
		check("busy", busy, 1);
		cio <= 2'h1;
		wait_rdy;
		check("io state", cst, 1);
		// A level wait never times out; only disabling frees it
		go(8'h89, 1);
		repeat (30) @(posedge clk);
		en <= 1'b0;
		@(posedge clk);
		en <= 1'b1;
		wait_rdy;
		check("divisor", div, 2);
		check("prescale", pre, 0);
		cmd(8'h96, 1);
		slow <= 1'b1;
		run(16'h8e01, 2, 2, 0);
		check("stretched", hi - h0 > 12, 1);
		cmd(8'h97, 1);
		check("adaptive", adapt, 0);
		p0 = oes;
		cmd(24'h92103c, 3);
		check("written", wr_seen, 16'h103c);
		check("drive", oes - p0, 6);
		cmd(32'h93012077, 4);
		check("written", wr_seen, 16'h2077);
		cmd(16'h9055, 2);
		cmd(24'h911234, 3);
		check("replies", rq.size(), 2);
		check("reply", rq[0], 8'h55 ^ 8'ha5);
		check("reply", rq[1], 8'h12 ^ 8'h34 ^ 8'ha5);
		cmd(8'h87, 1);
		@(posedge clk);
		check("flush", flushes, 1);
		report_and_stop;
	end
endmodule // tb
